// ---- core/lad_pkg.sv ----
// constants shared by the line alarm and drive monitor block
package lad_pkg;
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // transmit control offsets per channel
  localparam logic [7:0] TX_CTRL_CH0 = 8'h04;
  localparam logic [7:0] TX_CTRL_CH1 = 8'h0C;
  localparam logic [7:0] TX_CTRL_CH2 = 8'h14;
  // alarm status offsets per channel
  localparam logic [7:0] ALARM_STAT_CH0 = 8'h07;
  localparam logic [7:0] ALARM_STAT_CH1 = 8'h0F;
  localparam logic [7:0] ALARM_STAT_CH2 = 8'h17;
  // interrupt status and mask
  localparam logic [7:0] INT_STAT_ADDR = 8'h20;
  localparam logic [7:0] INT_MASK_ADDR = 8'h21;
  // transmit control fields
  localparam int TXC_BUILD_OUT = 0;
  localparam int TXC_SAMPLE_EDGE = 1;
  localparam int TXC_ALL_ONES = 2;
  localparam int TXC_ERR_INSERT = 4;
  localparam int TXC_INT_MONITOR = 5;
  localparam logic [7:0] TXC_WRITE_MASK = 8'h37;
  localparam logic [7:0] TXC_RESET = 8'h00;
  // alarm status fields
  localparam int STAT_DRIVE_ALARM = 0;
  localparam int STAT_SIGNAL_LOSS = 1;
  // drive monitor: bit periods without a mark before the alarm
  localparam int NO_PULSE_LIMIT = 128;
  localparam int RUN_W = 8;
  localparam logic [RUN_W-1:0] RUN_LIMIT = RUN_W'(NO_PULSE_LIMIT);
  // line rate modes
  localparam logic [1:0] MODE_E3 = 2'h0;
  localparam logic [1:0] MODE_DS3 = 2'h1;
  localparam logic [1:0] MODE_STS1 = 2'h2;
endpackage

// ---- core/lad_drive_mon.sv ----
// one channel's no-pulse run counter and drive monitor alarm
`timescale 1ns/1ps
module lad_drive_mon
  import lad_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic bit_tick, // one pulse per line bit period
  input wire logic mark_seen, // a mark of either polarity this bit
  output logic alarm // drive monitor alarm
);
  typedef struct packed {
    logic [RUN_W-1:0] run;
    logic alarm;
  } lad_mon_type;
  lad_mon_type state, next_state;

  // count idle bit periods and declare or clear the alarm
  always_comb begin
    next_state = state;
    if (bit_tick) begin
      if (mark_seen) begin
        next_state.run = '0;
        next_state.alarm = 1'b0;
      end else if (state.run != RUN_LIMIT) begin
        next_state.run = state.run + RUN_W'(1);
        if (state.run + RUN_W'(1) == RUN_LIMIT) begin
          next_state.alarm = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign alarm = state.alarm;
endmodule

// ---- core/lad_top.sv ----
// alarm status, drive monitor and transmit control for three line channels
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module lad_top
  import lad_pkg::*;
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // register address
  input wire logic [DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  output logic irq, // level interrupt
  input wire logic [NUM_CH*2-1:0] line_mode, // per channel rate mode
  input wire logic [NUM_CH-1:0] analog_loss, // analog loss detector
  input wire logic [NUM_CH-1:0] digital_loss, // digital loss detector
  input wire logic [NUM_CH-1:0] g775_loss, // E3 loss detector
  input wire logic [NUM_CH-1:0] tx_line_clock_in, // transmit line clock level
  input wire logic [NUM_CH-1:0] tx_pos_data_in, // positive rail data
  input wire logic [NUM_CH-1:0] tx_neg_data_in, // negative rail data
  input wire logic [NUM_CH-1:0] monitor_pos_in, // external monitor positive
  input wire logic [NUM_CH-1:0] monitor_neg_in, // external monitor negative
  output logic [NUM_CH-1:0] tx_line_pos_out, // line positive pulse
  output logic [NUM_CH-1:0] tx_line_neg_out, // line negative pulse
  output logic [NUM_CH-1:0] tx_build_out_select, // build-out select
  output logic [NUM_CH-1:0] error_insert, // one-cycle error insert pulse
  output logic [NUM_CH-1:0] signal_loss, // signal loss per channel
  output logic [NUM_CH-1:0] drive_monitor_alarm // drive alarm per channel
);
  typedef struct packed {
    logic [NUM_CH-1:0][DATA_W-1:0] tx_ctrl;
    logic [NUM_CH-1:0] clk_prev;
    logic [NUM_CH-1:0] pos_q;
    logic [NUM_CH-1:0] neg_q;
    logic [NUM_CH-1:0] tick;
    logic [NUM_CH-1:0] mark;
    logic [NUM_CH-1:0] err_pulse;
    logic [NUM_CH-1:0] loss;
    logic [NUM_CH-1:0] loss_prev;
    logic [NUM_CH-1:0] alarm_prev;
    logic [2*NUM_CH-1:0] int_stat;
    logic [2*NUM_CH-1:0] int_mask;
    logic [DATA_W-1:0] rdata;
  } lad_top_type;
  lad_top_type state, next_state;

  logic [NUM_CH-1:0] alarm;
  logic [NUM_CH-1:0] ctrl_hit;
  logic [NUM_CH-1:0] stat_hit;
  logic [2*NUM_CH-1:0] events;

  localparam logic [7:0] CTRL_ADDR [NUM_CH] = '{TX_CTRL_CH0, TX_CTRL_CH1, TX_CTRL_CH2};
  localparam logic [7:0] STAT_ADDR [NUM_CH] = '{ALARM_STAT_CH0, ALARM_STAT_CH1, ALARM_STAT_CH2};

  ////////////////////////////////////////////////////////////////////////////////
  // per channel drive monitors
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // decode this channel's addresses
      assign ctrl_hit[g] = (reg_addr == CTRL_ADDR[g]);
      assign stat_hit[g] = (reg_addr == STAT_ADDR[g]);
      lad_drive_mon u_mon (
        .clk(clk),
        .rst_n(rst_n),
        .bit_tick(state.tick[g]),
        .mark_seen(state.mark[g]),
        .alarm(alarm[g])
      );
    end
  endgenerate

  // rising edges of signal loss and drive alarm raise interrupt events
  assign events = {state.loss & ~state.loss_prev, alarm & ~state.alarm_prev};

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic edge_ok;
    logic in_pos;
    logic in_neg;
    logic [1:0] mode;
    logic [DATA_W-1:0] new_ctrl;
    edge_ok = 1'b0;
    in_pos = 1'b0;
    in_neg = 1'b0;
    mode = MODE_E3;
    new_ctrl = '0;
    next_state = state;
    next_state.clk_prev = tx_line_clock_in;
    next_state.alarm_prev = alarm;
    next_state.loss_prev = state.loss;
    next_state.err_pulse = '0;
    next_state.rdata = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      // sample data on the selected edge of the line clock
      if (state.tx_ctrl[c][TXC_SAMPLE_EDGE]) begin
        edge_ok = tx_line_clock_in[c] & ~state.clk_prev[c];
      end else begin
        edge_ok = ~tx_line_clock_in[c] & state.clk_prev[c];
      end
      next_state.tick[c] = edge_ok;
      if (edge_ok) begin
        if (state.tx_ctrl[c][TXC_ALL_ONES]) begin
          // all ones in AMI alternates polarity each bit
          next_state.pos_q[c] = ~state.pos_q[c] | state.neg_q[c];
          next_state.neg_q[c] = state.pos_q[c] & ~state.neg_q[c];
        end else begin
          next_state.pos_q[c] = tx_pos_data_in[c];
          next_state.neg_q[c] = tx_neg_data_in[c];
        end
      end
      // choose where the monitor looks for pulses
      if (state.tx_ctrl[c][TXC_INT_MONITOR]) begin
        in_pos = state.pos_q[c];
        in_neg = state.neg_q[c];
      end else begin
        in_pos = monitor_pos_in[c];
        in_neg = monitor_neg_in[c];
      end
      next_state.mark[c] = in_pos | in_neg;
      // loss source by rate
      mode = line_mode[2*c +: 2];
      if (mode == MODE_E3) begin
        next_state.loss[c] = g775_loss[c];
      end else begin
        next_state.loss[c] = analog_loss[c] | digital_loss[c];
      end
      // control register write
      if (reg_wr && ctrl_hit[c]) begin
        new_ctrl = reg_wdata & TXC_WRITE_MASK;
        next_state.tx_ctrl[c] = new_ctrl;
        next_state.err_pulse[c] = new_ctrl[TXC_ERR_INSERT] &
                                  ~state.tx_ctrl[c][TXC_ERR_INSERT];
      end
    end
    // register reads
    if (reg_rd) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (ctrl_hit[c]) begin
          next_state.rdata = state.tx_ctrl[c];
        end
        if (stat_hit[c]) begin
          next_state.rdata[STAT_DRIVE_ALARM] = alarm[c];
          next_state.rdata[STAT_SIGNAL_LOSS] = state.loss[c];
        end
      end
      if (reg_addr == INT_STAT_ADDR) begin
        next_state.rdata = DATA_W'(state.int_stat);
      end
      if (reg_addr == INT_MASK_ADDR) begin
        next_state.rdata = DATA_W'(state.int_mask);
      end
    end
    // sticky status: read clears, a new event wins
    if (reg_rd && reg_addr == INT_STAT_ADDR) begin
      next_state.int_stat = events;
    end else begin
      next_state.int_stat = state.int_stat | events;
    end
    if (reg_wr && reg_addr == INT_MASK_ADDR) begin
      next_state.int_mask = reg_wdata[2*NUM_CH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  always_comb begin
    reg_rdata = state.rdata;
    irq = |(state.int_stat & state.int_mask);
    tx_line_pos_out = state.pos_q;
    tx_line_neg_out = state.neg_q;
    error_insert = state.err_pulse;
    signal_loss = state.loss;
    drive_monitor_alarm = alarm;
    for (int c = 0; c < NUM_CH; c++) begin
      tx_build_out_select[c] = state.tx_ctrl[c][TXC_BUILD_OUT];
    end
  end
endmodule

// ---- verif/lad_line_model.sv ----
// far side model: line clock, rail data and monitor wiring
`timescale 1ns/1ps
module lad_line_model
  import lad_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic marks, // send marks
  input wire logic cut, // monitor wire broken
  input wire logic [NUM_CH-1:0] pos_out, // block positive out
  input wire logic [NUM_CH-1:0] neg_out, // block negative out
  output logic [NUM_CH-1:0] lclk, // line clock
  output logic [NUM_CH-1:0] pdata, // positive rail
  output logic [NUM_CH-1:0] ndata, // negative rail
  output logic [NUM_CH-1:0] mpos, // monitor positive
  output logic [NUM_CH-1:0] mneg // monitor negative
);
  logic [1:0] div;
  logic flip;
  // bit period of four clocks; rails move at the rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 2'h0;
      lclk <= '0;
      pdata <= '0;
      ndata <= '0;
      flip <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div[0]) lclk <= ~lclk;
      if (div == 2'h1) begin
        flip <= ~flip;
        pdata <= {NUM_CH{marks & flip}};
        ndata <= {NUM_CH{marks & ~flip}};
      end
    end
  end
  // a broken wire leaves the terminated line at rest
  assign mpos = cut ? '0 : pos_out;
  assign mneg = cut ? '0 : neg_out;
endmodule

// ---- verif/lad_top_chk.sv ----
// port checker for the line alarm block
`timescale 1ns/1ps
module lad_top_chk
  import lad_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [ADDR_W-1:0] reg_addr, // address
  input wire logic [DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [DATA_W-1:0] reg_rdata, // read data
  input wire logic irq, // interrupt
  input wire logic [NUM_CH*2-1:0] line_mode, // modes
  input wire logic [NUM_CH-1:0] analog_loss, // analog
  input wire logic [NUM_CH-1:0] digital_loss, // digital
  input wire logic [NUM_CH-1:0] g775_loss, // E3 detector
  input wire logic [NUM_CH-1:0] tx_build_out_select, // build-out
  input wire logic [NUM_CH-1:0] error_insert, // error pulse
  input wire logic [NUM_CH-1:0] signal_loss, // loss
  input wire logic [NUM_CH-1:0] drive_monitor_alarm // alarm
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_LOSS0: assert property (rst_n |=> signal_loss[0] ==
    $past(line_mode[1:0] == MODE_E3 ? g775_loss[0] : analog_loss[0] | digital_loss[0]))
    else $error("ch0 loss flag wrong");
  AST_LOSS2: assert property ((line_mode[5:4] != MODE_E3 && digital_loss[2]) |=>
    signal_loss[2]) else $error("ch2 loss flag missed");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_UNUSED: assert property ((reg_rd && reg_addr == TX_CTRL_CH0) |=>
    (reg_rdata & 8'hC8) == 8'h00) else $error("unused control bits set");
  AST_STAT_RD: assert property ((reg_rd && reg_addr == ALARM_STAT_CH0) |=>
    reg_rdata[1:0] == {$past(signal_loss[0]), $past(drive_monitor_alarm[0])})
    else $error("status read wrong");
  AST_ERR_SRC: assert property (error_insert[0] |->
    $past(reg_wr && reg_addr == TX_CTRL_CH0 && reg_wdata[TXC_ERR_INSERT]))
    else $error("error pulse without write");
  AST_ERR_ONE: assert property (error_insert[1] |=> !error_insert[1])
    else $error("error pulse too long");
  AST_BUILD_OUT: assert property ((reg_wr && reg_addr == TX_CTRL_CH0) |=>
    tx_build_out_select[0] == $past(reg_wdata[0])) else $error("build-out wrong");
  // main scenarios
  cover property ($rose(drive_monitor_alarm[0]));
  cover property (error_insert[2]);
  cover property ($rose(irq));
endmodule
bind lad_top lad_top_chk chk_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .irq, .line_mode, .analog_loss, .digital_loss, .g775_loss,
  .tx_build_out_select, .error_insert, .signal_loss, .drive_monitor_alarm);

// ---- verif/tb.sv ----
// testbench for the line alarm block
`timescale 1ns/1ps
module tb;
  import lad_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, marks = 1, cut = 0, irq;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  logic [5:0] line_mode = 6'h00;
  logic [2:0] analog_loss = 3'h0, digital_loss = 3'h0, g775_loss = 3'h0;
  logic [2:0] lclk, pdata, ndata, mpos, mneg, pout, nout, build, err, loss, alarm;
  int fails = 0, checks = 0;
  always #5 clk = ~clk;
  lad_top dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .line_mode, .analog_loss, .digital_loss, .g775_loss, .tx_line_clock_in(lclk),
    .tx_pos_data_in(pdata), .tx_neg_data_in(ndata), .monitor_pos_in(mpos),
    .monitor_neg_in(mneg), .tx_line_pos_out(pout), .tx_line_neg_out(nout),
    .tx_build_out_select(build), .error_insert(err), .signal_loss(loss),
    .drive_monitor_alarm(alarm));
  lad_line_model line (.clk, .rst_n, .marks, .cut, .pos_out(pout), .neg_out(nout),
    .lclk, .pdata, .ndata, .mpos, .mneg);
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  // write all three control registers, then let n bit periods pass
  task automatic wall(input logic [7:0] d, input int n);
    for (int c = 0; c < 3; c++) wr(8'h04 + 8'(c * 8), d);
    repeat (n * 4) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test;
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      rd(8'h04 + 8'(c * 8));
      chk("ctrl reset", rd_val, TXC_RESET);
      wr(8'h04 + 8'(c * 8), 8'hFF);
      chk("error pulse", {5'h00, err}, 8'(1 << c));
      chk("build out", {5'h00, build}, 8'(1 << c));
      rd(8'h04 + 8'(c * 8));
      chk("ctrl mask", rd_val, TXC_WRITE_MASK);
      wr(8'h04 + 8'(c * 8), 8'h10);
      chk("no repeat", {5'h00, err}, 8'h00);
      wr(8'h04 + 8'(c * 8), 8'h00);
    end
    rd(8'h30);
    chk("unmapped", rd_val, 8'h00);
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 8; d++) begin
        @(posedge clk);
        line_mode <= 6'(m * 21);
        g775_loss <= {3{d[0]}};
        analog_loss <= {3{d[1]}};
        digital_loss <= {3{d[2]}};
        rd(8'h07 + 8'(m * 8));
        chk("loss", rd_val & 8'h02, (m == 0 ? d[0] : d[1] | d[2]) ? 8'h02 : 8'h00);
      end
    end
    rd(INT_STAT_ADDR);
    @(posedge clk);
    marks <= 1'b0;
    wall(8'h00, 117);
    chk("alarm early", {5'h00, alarm}, 8'h00);
    wall(8'h00, 16);
    chk("alarm set", {5'h00, alarm}, 8'h07);
    rd(8'h07);
    chk("alarm stat", rd_val & 8'h01, 8'h01);
    // status is read-only: a write must leave drive alarm and signal loss showing
    wr(8'h07, 8'h00);
    rd(8'h07);
    chk("stat fixed", rd_val, 8'h03);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(INT_MASK_ADDR, 8'h01);
    @(posedge clk);
    #1;
    chk("irq on", {7'h00, irq}, 8'h01);
    rd(INT_STAT_ADDR);
    chk("int stat", rd_val, 8'h07);
    @(posedge clk);
    #1;
    chk("irq cleared", {7'h00, irq}, 8'h00);
    marks <= 1'b1;
    wall(8'h00, 3);
    chk("alarm clear", {5'h00, alarm}, 8'h00);
    // rising edge select: rails reach the outputs one clock after the rise is seen
    wall(8'h02, 2);
    @(posedge lclk[0]);
    @(posedge clk);
    #1;
    chk("rise edge", {2'h0, pout, nout}, {2'h0, pdata, ndata});
    // falling edge select: the outputs still hold the previous bit there
    wall(8'h00, 2);
    @(posedge lclk[0]);
    @(posedge clk);
    #1;
    chk("fall edge", {2'h0, pout, nout}, {2'h0, ndata, pdata});
    cut <= 1'b1;
    wall(8'h00, 136);
    chk("ext dead", {5'h00, alarm}, 8'h07);
    wall(8'h20, 3);
    chk("internal", {5'h00, alarm}, 8'h00);
    marks <= 1'b0;
    wall(8'h20, 136);
    chk("int idle", {5'h00, alarm}, 8'h07);
    chk("rails idle", {2'h0, pout, nout}, 8'h00);
    wall(8'h24, 3);
    chk("all ones", {5'h00, alarm}, 8'h00);
    chk("ami ones", {5'h00, pout ^ nout}, 8'h07);
    end_of_test();
  end
endmodule
